// ### bench/agcr_regs_assertions.sv
// checker for the pin config, id and channel map register bank
// assumes: bound into agcr_regs, no apb wait states on CORE_CLK
`timescale 1ns/1ns
module agcr_regs_assertions #(
    parameter [15:0] ID_CODE = 16'h5a3c  // arbitrary value
) (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // general pins
    input wire logic        PIN0_OUT,
    input wire logic        PIN0_OE_N,
    input wire logic        PIN1_OUT,
    input wire logic        PIN1_OE_N
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // completed write to the pin config and completed read
    wire pin_wr = PSEL & PENABLE & PREADY & PWRITE & (PADDR == 12'h018) & PSTRB[0];
    wire rd_at  = PSEL & PENABLE & PREADY & !PWRITE;

    apb_answer_time_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in first access cycle");
    ready_single_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    pin0_drive_a: assert property (pin_wr |-> ##2 (PIN0_OE_N == !$past(PWDATA[2], 2)))
        else $error("pin 0 drive does not follow its enable");
    pin1_drive_a: assert property (pin_wr |-> ##2 (PIN1_OE_N == !$past(PWDATA[3], 2)))
        else $error("pin 1 drive does not follow its enable");
    pin_levels_a: assert property (pin_wr |-> ##2 ({PIN1_OUT, PIN0_OUT} == $past(PWDATA[1:0], 2)))
        else $error("driven levels differ from written bits");
    id_readonly_a: assert property (rd_at && PADDR == 12'h01c |-> PRDATA == {16'h0000, ID_CODE})
        else $error("id read wrong");
    pin_reserved_a: assert property (rd_at && PADDR == 12'h018 |-> PRDATA[31:6] == 26'h0)
        else $error("pin config reserved bits not zero");
    map_reserved_a: assert property (rd_at && PADDR == 12'h040 |-> !PRDATA[14] && PRDATA[11:10] == 2'h0)
        else $error("map reserved bits not zero");
    bad_addr_error_a: assert property (PSEL && PENABLE && PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
        else $error("unaligned access not refused");
endmodule
bind agcr_regs agcr_regs_assertions #(.ID_CODE(ID_CODE)) chk_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN0_OUT(PIN0_OUT),
    .PIN0_OE_N(PIN0_OE_N), .PIN1_OUT(PIN1_OUT), .PIN1_OE_N(PIN1_OE_N));

// ### bench/agcr_regs_tb.sv
// self-checking bench for the register bank over apb
// assumes: agcr_regs with no apb wait states, 125 MHz clock
`timescale 1ns/1ns
module agcr_regs_tb;
    logic        CORE_CLK, RESET, PSEL, PENABLE, PWRITE, PIN0_IN, PIN1_IN, CONV_DONE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, q;
    logic [3:0]  PSTRB;
    logic        PREADY, PSLVERR, PIN0_OUT, PIN0_OE_N, PIN1_OUT, PIN1_OE_N, CONV_RUN, e;
    logic [1:0]  ACTIVE_CH, ACTIVE_SETUP;
    logic [4:0]  ACTIVE_POS, ACTIVE_NEG;
    integer      err_total = 0, n_tests = 0, s;
    localparam logic [15:0] IDV = 16'h3c5a;  // arbitrary value

    agcr_regs #(.ID_CODE(IDV)) uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN0_IN(PIN0_IN),
        .PIN0_OUT(PIN0_OUT), .PIN0_OE_N(PIN0_OE_N), .PIN1_IN(PIN1_IN), .PIN1_OUT(PIN1_OUT),
        .PIN1_OE_N(PIN1_OE_N), .CONV_DONE(CONV_DONE), .ACTIVE_CH(ACTIVE_CH),
        .CONV_RUN(CONV_RUN), .ACTIVE_SETUP(ACTIVE_SETUP), .ACTIVE_POS(ACTIVE_POS),
        .ACTIVE_NEG(ACTIVE_NEG));

    // free running clock
    initial begin
        CORE_CLK = 0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    task automatic cyc(input integer n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, result left in q and e
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        cyc(1);
        PENABLE <= 1;
        cyc(1);
        while (PREADY !== 1'b1 && n < 20) begin
            n = n + 1;
            cyc(1);
        end
        if (n == 20) err_total = err_total + 1;
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        cyc(1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 32'h0);
        chk("read data", q, x);
        chk("error flag", {31'h0, e}, 32'h0);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // hang guard
    initial begin
        cyc(3000);
        err_total = err_total + 1;
        complete_run;
    end

    initial begin
        RESET = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0;
        PSTRB = 4'hf; PIN0_IN = 0; PIN1_IN = 1; CONV_DONE = 0;
        cyc(8);
        RESET <= 0;
        cyc(1);
        // reset values and read-only id
        rd(12'h040, 32'h8001);
        rd(12'h018, 32'h0);
        chk("run flag", CONV_RUN, 1);
        chk("neg input", {ACTIVE_POS, ACTIVE_NEG}, 10'h001);
        apb(1, 12'h01c, 32'hffff);
        rd(12'h01c, {16'h0, IDV});
        // all enables set: levels read from the pins
        apb(1, 12'h018, 32'hff);
        cyc(3);
        rd(12'h018, 32'h3e);
        chk("pin drive", {PIN1_OE_N, PIN0_OE_N, PIN1_OUT, PIN0_OUT}, 4'b0011);
        apb(1, 12'h018, 32'h0e);
        cyc(1);
        rd(12'h018, 32'h0e);
        chk("pin drive", {PIN1_OE_N, PIN0_OE_N, PIN1_OUT, PIN0_OUT}, 4'b0010);
        // no output enables: pins float, stored bits or sampled input levels read back
        apb(1, 12'h018, 32'h03);
        cyc(1);
        rd(12'h018, 32'h03);
        chk("pin float", {PIN1_OE_N, PIN0_OE_N}, 2'b11);
        apb(1, 12'h018, 32'h10);
        PIN0_IN <= 1;
        cyc(3);
        rd(12'h018, 32'h11);
        chk("pin float", PIN0_OE_N, 1);
        apb(1, 12'h018, 32'h20);
        cyc(3);
        rd(12'h018, 32'h22);
        // channel map fields, reserved bits dropped
        apb(1, 12'h040, 32'hffff);
        rd(12'h040, 32'hb3ff);
        chk("fields", {ACTIVE_SETUP, ACTIVE_POS, ACTIVE_NEG}, 12'hfff);
        for (s = 0; s < 4; s++) begin
            apb(1, 12'h040, 32'h8001 | (s << 12));
            cyc(2);
            chk("setup", ACTIVE_SETUP, s[1:0]);
        end
        // two channels enabled: stepping on each conversion
        apb(1, 12'h044, 32'h9022);
        for (s = 1; s < 3; s++) begin
            CONV_DONE <= 1;
            cyc(1);
            CONV_DONE <= 0;
            cyc(3);
            chk("sequence", {ACTIVE_CH, ACTIVE_SETUP, ACTIVE_NEG}, s == 1 ? 9'h0a2 : 9'h061);
        end
        // unaligned and unmapped accesses refused
        apb(1, 12'h041, 32'h0);
        chk("unaligned", e, 1);
        apb(0, 12'h0fc, 32'h0);
        chk("unmapped", e, 1);
        rd(12'h040, 32'hb001);
        // channel zero disabled: sequencer leaves it unprompted
        apb(1, 12'h040, 32'h0001);
        cyc(2);
        chk("leave disabled", ACTIVE_CH, 1);
        apb(1, 12'h044, 32'h0000);
        cyc(2);
        chk("run flag", CONV_RUN, 0);
        // byte lanes: pin config needs lane 0, map high byte lane 1
        PSTRB <= 4'he;
        apb(1, 12'h018, 32'h0c);
        PSTRB <= 4'h2;
        apb(1, 12'h040, 32'hffff);
        PSTRB <= 4'hf;
        rd(12'h018, 32'h22);
        rd(12'h040, 32'hb301);
        complete_run;
    end
endmodule

// ### rtl/agcr_consts.vh
// constants for the pin config, id and channel map register bank
// assumes: included by bare name from the rtl/ folder
`ifndef AGCR_CONSTS_VH
`define AGCR_CONSTS_VH

// register indices; byte address is four times the index
`define AGCR_IDX_PINCFG   8'h06
`define AGCR_IDX_IDCODE   8'h07
`define AGCR_IDX_MAP0     8'h10

// pin config register, low byte only
`define AGCR_PINCFG_MASK  8'h3f
`define AGCR_PINCFG_RST   8'h00
`define AGCR_BIT_IN1      5
`define AGCR_BIT_IN0      4
`define AGCR_BIT_OUT1     3
`define AGCR_BIT_OUT0     2
`define AGCR_BIT_LVL1     1
`define AGCR_BIT_LVL0     0

// channel map registers
`define AGCR_MAP_MASK     16'hb3ff
`define AGCR_MAP0_RST     16'h8001
`define AGCR_MAPN_RST     16'h0001
`define AGCR_BIT_CHEN     15
`define AGCR_SETUP_HI     13
`define AGCR_SETUP_LO     12
`define AGCR_POS_HI       9
`define AGCR_POS_LO       5
`define AGCR_NEG_HI       4
`define AGCR_NEG_LO       0

// apb answer timing, in clock cycles after the setup edge
`define AGCR_APB_WAIT     1

`endif

// ### rtl/agcr_regs.v
// register bank: general pin config, id code and channel maps,
// with the channel sequencer and two general pins
// assumes: apb master on CORE_CLK, pins outside this clock domain
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "agcr_consts.vh"
module agcr_regs #(
    parameter        NUM_CH  = 4,
    parameter        CW      = 2,
    parameter [15:0] ID_CODE = 16'h5a3c  // arbitrary value
) (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        RESET,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    input  wire [3:0]  PSTRB,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // general pin zero
    input  wire        PIN0_IN,
    output reg         PIN0_OUT,
    output reg         PIN0_OE_N,
    // general pin one
    input  wire        PIN1_IN,
    output reg         PIN1_OUT,
    output reg         PIN1_OE_N,
    // converter side
    input  wire        CONV_DONE,
    output wire [1:0]  ACTIVE_CH,
    output wire        CONV_RUN,
    output reg  [1:0]  ACTIVE_SETUP,
    output reg  [4:0]  ACTIVE_POS,
    output reg  [4:0]  ACTIVE_NEG
);

    // pin config storage, low byte
    reg  [7:0]  pincfg_r;
    // channel map storage, one entry per channel
    reg  [15:0] map_r [0:NUM_CH-1];
    // pin input synchronisers
    reg         pin0_meta_r;
    reg         pin0_sync_r;
    reg         pin1_meta_r;
    reg         pin1_sync_r;

    // apb decode
    wire        aligned;     // word aligned address
    wire [7:0]  idx;         // register index
    wire [7:0]  map_off;     // offset into channel maps
    wire        hit_pin;     // pin config selected
    wire        hit_id;      // id register selected
    wire        hit_map;     // some channel map selected
    wire        hit;         // any mapped register
    wire [CW-1:0] map_sel;   // channel map entry
    wire        setup_go;    // setup phase edge
    wire        wr_go;       // write completes this edge
    reg  [31:0] rd_val;      // read data mux
    wire [15:0] map_mask;    // writable bits of a channel map

    // channel enables for the sequencer
    wire [NUM_CH-1:0] ch_en;
    wire [CW-1:0]     cur_ch;

    // address decode
    assign aligned  = (PADDR[1:0] == 2'b00);
    assign idx      = PADDR[9:2];
    assign map_off  = idx - `AGCR_IDX_MAP0;
    assign hit_pin  = aligned && (idx == `AGCR_IDX_PINCFG);
    assign hit_id   = aligned && (idx == `AGCR_IDX_IDCODE);
    assign hit_map  = aligned && (idx >= `AGCR_IDX_MAP0)
                      && (map_off < NUM_CH)
                      && (PADDR[11:10] == 2'b00);
    assign hit      = hit_pin || hit_id || hit_map;
    assign map_sel  = map_off[CW-1:0];
    assign map_mask = `AGCR_MAP_MASK;
    assign setup_go = PSEL && !PENABLE;
    assign wr_go    = PSEL && PENABLE && PREADY && PWRITE;

    // read mux; reserved bits come back zero
    always @* begin
        rd_val = 32'h0000_0000;
        if (hit_pin) begin
            rd_val[7:0] = pincfg_r;
            // sampled level when input enabled, else stored value
            if (pincfg_r[`AGCR_BIT_IN1]) begin
                rd_val[`AGCR_BIT_LVL1] = pin1_sync_r;
            end
            if (pincfg_r[`AGCR_BIT_IN0]) begin
                rd_val[`AGCR_BIT_LVL0] = pin0_sync_r;
            end
        end else if (hit_id) begin
            rd_val[15:0] = ID_CODE;
        end else if (hit_map) begin
            rd_val[15:0] = map_r[map_sel];
        end
    end

    // apb answer: ready in the first access cycle, no wait state, data latched at setup
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (setup_go) begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
            PREADY  <= 1'b1;
            PSLVERR <= !hit;
        end else begin
            // access phase done, or master left
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // pin config register write, low byte lane only
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            pincfg_r <= `AGCR_PINCFG_RST;
        end else if (wr_go && hit_pin && !PSLVERR && PSTRB[0]) begin
            // reserved bits dropped on store
            pincfg_r <= PWDATA[7:0] & `AGCR_PINCFG_MASK;
        end
    end

    // channel map entries, one writer each
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : map_gen
            wire sel_g;   // this entry addressed
            assign sel_g = wr_go && hit_map && (map_sel == g);
            always @(posedge CORE_CLK) begin
                if (RESET) begin
                    // channel zero on, negative input one
                    map_r[g] <= (g == 0) ? `AGCR_MAP0_RST
                                         : `AGCR_MAPN_RST;
                end else if (sel_g) begin
                    // per byte lane, reserved bits kept zero
                    if (PSTRB[0]) begin
                        map_r[g][7:0] <= PWDATA[7:0];
                    end
                    if (PSTRB[1]) begin
                        map_r[g][15:8] <= PWDATA[15:8]
                                          & map_mask[15:8];
                    end
                end
            end
            assign ch_en[g] = map_r[g][`AGCR_BIT_CHEN];
        end
    endgenerate

    // two flip-flop synchronisers on the pin inputs
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            pin0_meta_r <= 1'b0;
            pin0_sync_r <= 1'b0;
            pin1_meta_r <= 1'b0;
            pin1_sync_r <= 1'b0;
        end else begin
            pin0_meta_r <= PIN0_IN;
            pin0_sync_r <= pin0_meta_r;
            pin1_meta_r <= PIN1_IN;
            pin1_sync_r <= pin1_meta_r;
        end
    end

    // pin drivers; enable is active low, off after reset
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            PIN0_OUT  <= 1'b0;
            PIN0_OE_N <= 1'b1;
            PIN1_OUT  <= 1'b0;
            PIN1_OE_N <= 1'b1;
        end else begin
            // stored level drives only when output enabled
            PIN0_OUT  <= pincfg_r[`AGCR_BIT_LVL0];
            PIN1_OUT  <= pincfg_r[`AGCR_BIT_LVL1];
            // no output enable leaves the pin floating
            PIN0_OE_N <= !pincfg_r[`AGCR_BIT_OUT0];
            PIN1_OE_N <= !pincfg_r[`AGCR_BIT_OUT1];
        end
    end

    // sequencer over the enabled channels
    agcr_seq #(
        .NUM_CH    (NUM_CH),
        .CW        (CW)
    ) u_seq (
        .clk       (CORE_CLK),
        .rst       (RESET),
        .ch_en     (ch_en),
        .conv_done (CONV_DONE),
        .cur_ch_r  (cur_ch),
        .run_r     (CONV_RUN)
    );

    assign ACTIVE_CH = cur_ch;

    // setup and inputs of the selected channel
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            ACTIVE_SETUP <= 2'b00;
            ACTIVE_POS   <= 5'h00;
            ACTIVE_NEG   <= 5'h01;
        end else begin
            // one of four setups per channel
            ACTIVE_SETUP <= map_r[cur_ch][`AGCR_SETUP_HI:`AGCR_SETUP_LO];
            ACTIVE_POS   <= map_r[cur_ch][`AGCR_POS_HI:`AGCR_POS_LO];
            ACTIVE_NEG   <= map_r[cur_ch][`AGCR_NEG_HI:`AGCR_NEG_LO];
        end
    end

endmodule

// ### rtl/agcr_seq.v
// channel sequencer: steps through enabled channels on each
// finished conversion
// assumes: conv_done is a one-cycle pulse on the same clock
`timescale 1ns/1ns
module agcr_seq #(
    parameter NUM_CH = 4,
    parameter CW     = 2
) (
    // clock and reset
    input  wire              clk,
    input  wire              rst,
    // channel enables and conversion event
    input  wire [NUM_CH-1:0] ch_en,
    input  wire              conv_done,
    // selected channel and run flag
    output reg  [CW-1:0]     cur_ch_r,
    output reg               run_r
);

    reg [CW-1:0] next_ch;   // next enabled channel after current
    reg          found;     // some other channel enabled
    reg [CW-1:0] cand;      // candidate index in search
    integer      k;         // search offset

    // search upward, wrapping, for the next enabled channel
    always @* begin
        next_ch = cur_ch_r;
        found   = 1'b0;
        cand    = cur_ch_r;
        for (k = 1; k < NUM_CH; k = k + 1) begin
            cand = cur_ch_r + k[CW-1:0];
            if (!found && ch_en[cand]) begin
                next_ch = cand;
                found   = 1'b1;
            end
        end
    end

    // advance on a finished conversion, or leave a disabled one
    always @(posedge clk) begin
        if (rst) begin
            cur_ch_r <= {CW{1'b0}};
            run_r    <= 1'b0;
        end else begin
            run_r <= |ch_en;
            // lone channel: search finds nothing, stays put
            if (found && (conv_done || !ch_en[cur_ch_r])) begin
                cur_ch_r <= next_ch;
            end
        end
    end

endmodule
